// [pkg/tscf_pkg.sv]
// Shared constants and carrier types for the stage configuration bank
package tscf_pkg;

  // Geometry of the bank
  localparam int NUM_STAGES = 12;
  localparam int NUM_INPUTS = 14;
  localparam int INPUTS_PER_REG = 7;
  localparam int REG_WIDTH = 16;
  localparam int STAGE_BITS = 4;

  // Register indices; byte address is four times the index
  localparam logic [9:0] STAGE_BASE_IDX = 10'h080;
  localparam logic [9:0] STAGE_LAST_IDX = 10'h0df;
  localparam logic [3:0] STAGE_STRIDE = 4'h8;
  localparam logic [1:0] SUB_LOWER_ROUTING = 2'h0;
  localparam logic [1:0] SUB_UPPER_ROUTING = 2'h1;
  localparam logic [1:0] SUB_OFFSET_CONTROL = 2'h2;
  localparam logic [1:0] SUB_SENSITIVITY = 2'h3;

  // Reset value of every stored field
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // Routing field codes
  localparam logic [1:0] ROUTE_OPEN = 2'h0;
  localparam logic [1:0] ROUTE_NEG = 2'h1;
  localparam logic [1:0] ROUTE_POS = 2'h2;
  localparam logic [1:0] ROUTE_BIAS = 2'h3;

  // Upper routing register bit positions
  localparam int NEG_INJ_OFF_BIT = 14;
  localparam int POS_INJ_OFF_BIT = 15;

  // Offset control field positions
  localparam int NEG_CODE_LSB = 0;
  localparam int NEG_STEER_BIT = 7;
  localparam int POS_CODE_LSB = 8;
  localparam int POS_STEER_BIT = 15;
  localparam int INJ_CODE_W = 7;
  // Offset step in femtofarads and nominal span
  localparam logic [15:0] INJ_LSB_FF = 16'h00a0;
  localparam logic [15:0] INJ_RANGE_FF = 16'h4e20;

  // Sensitivity field positions
  localparam int NEG_TRIP_LSB = 0;
  localparam int NEG_PEAK_LSB = 4;
  localparam int POS_TRIP_LSB = 8;
  localparam int POS_PEAK_LSB = 12;
  localparam logic [15:0] SENS_UNUSED_MASK = 16'h8080;

  // Threshold percentages in hundredths of a percent
  localparam logic [13:0] TRIP_X100 [16] = '{
    14'h09c4, 14'h0b9d, 14'h0d70, 14'h0f44,
    14'h111b, 14'h12ef, 14'h14c3, 14'h1697,
    14'h186b, 14'h1a42, 14'h1c16, 14'h1dea,
    14'h1fc0, 14'h2194, 14'h2368, 14'h253c};

  // Peak detect: base percent, step, last defined code
  localparam logic [6:0] PEAK_BASE_PCT = 7'h28;
  localparam logic [6:0] PEAK_STEP_PCT = 7'h0a;
  localparam logic [2:0] PEAK_LAST_CODE = 3'h5;

  // AXI4-Lite responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Decoded switch matrix routing for all fourteen inputs
  typedef struct packed {
    logic [13:0] to_neg;
    logic [13:0] to_pos;
    logic [13:0] to_bias;
  } tscf_route_t;

  // Decoded offset injector settings
  typedef struct packed {
    logic neg_en;
    logic [6:0] neg_code;
    logic neg_to_pos;
    logic pos_en;
    logic [6:0] pos_code;
    logic pos_to_neg;
  } tscf_inject_t;

  // Decoded threshold and peak settings
  typedef struct packed {
    logic [13:0] neg_trip_x100;
    logic [6:0] neg_peak_pct;
    logic neg_peak_ok;
    logic [13:0] pos_trip_x100;
    logic [6:0] pos_peak_pct;
    logic pos_peak_ok;
  } tscf_sense_t;

  // Everything one stage presents to the analogue side
  typedef struct packed {
    tscf_route_t route;
    tscf_inject_t inject;
    tscf_sense_t sense;
  } tscf_stage_t;

endpackage

// [design/tscf_route_decode.sv]
// Two-bit routing codes of a group of inputs to switch enables
`timescale 1ns/1ps
module tscf_route_decode
  import tscf_pkg::*;
#(
  parameter int N = 7
) (
  input wire logic [2*N-1:0] codes, // Packed two-bit routing fields
  output logic [N-1:0] to_neg,      // Input joins converter negative
  output logic [N-1:0] to_pos,      // Input joins converter positive
  output logic [N-1:0] to_bias      // Input tied to bias
);

  // One decoder per input; open code drives none of the three
  for (genvar i = 0; i < N; i++) begin : g_in
    assign to_neg[i] = (codes[2*i +: 2] == ROUTE_NEG);
    assign to_pos[i] = (codes[2*i +: 2] == ROUTE_POS);
    assign to_bias[i] = (codes[2*i +: 2] == ROUTE_BIAS);
  end

endmodule

// [design/tscf_stage_decode.sv]
// Decodes one stage's four configuration words into front-end settings
`timescale 1ns/1ps
module tscf_stage_decode
  import tscf_pkg::*;
(
  input wire logic [15:0] lower_routing, // Inputs zero to six
  input wire logic [15:0] upper_routing, // Inputs seven to thirteen
  input wire logic [15:0] offset_ctrl,   // Offset injector control
  input wire logic [15:0] sens_ctrl,     // Threshold and peak control
  output tscf_stage_t dec                // Decoded settings
);

  logic [6:0] lo_neg, lo_pos, lo_bias;
  logic [6:0] up_neg, up_pos, up_bias;

  tscf_route_decode #(.N(INPUTS_PER_REG)) u_lower (
    .codes(lower_routing[13:0]),
    .to_neg(lo_neg),
    .to_pos(lo_pos),
    .to_bias(lo_bias)
  );

  tscf_route_decode #(.N(INPUTS_PER_REG)) u_upper (
    .codes(upper_routing[13:0]),
    .to_neg(up_neg),
    .to_pos(up_pos),
    .to_bias(up_bias)
  );

  // Peak level: undefined codes give zero and a cleared ok flag
  function automatic logic [7:0] peak_of(input logic [2:0] code);
    logic [6:0] pct;
    pct = PEAK_BASE_PCT + 7'(code) * PEAK_STEP_PCT;
    if (code > PEAK_LAST_CODE) begin
      peak_of = 8'h00;
    end else begin
      peak_of = {pct, 1'b1};
    end
  endfunction

  always_comb begin
    dec.route.to_neg = {up_neg, lo_neg};
    dec.route.to_pos = {up_pos, lo_pos};
    dec.route.to_bias = {up_bias, lo_bias};
    dec.inject.neg_en = ~upper_routing[NEG_INJ_OFF_BIT];
    dec.inject.pos_en = ~upper_routing[POS_INJ_OFF_BIT];
    dec.inject.neg_code = offset_ctrl[NEG_CODE_LSB +: INJ_CODE_W];
    dec.inject.neg_to_pos = offset_ctrl[NEG_STEER_BIT];
    dec.inject.pos_code = offset_ctrl[POS_CODE_LSB +: INJ_CODE_W];
    dec.inject.pos_to_neg = offset_ctrl[POS_STEER_BIT];
    dec.sense.neg_trip_x100 = TRIP_X100[sens_ctrl[NEG_TRIP_LSB +: 4]];
    {dec.sense.neg_peak_pct, dec.sense.neg_peak_ok} =
      peak_of(sens_ctrl[NEG_PEAK_LSB +: 3]);
    dec.sense.pos_trip_x100 = TRIP_X100[sens_ctrl[POS_TRIP_LSB +: 4]];
    {dec.sense.pos_peak_pct, dec.sense.pos_peak_ok} =
      peak_of(sens_ctrl[POS_PEAK_LSB +: 3]);
  end

endmodule

// [design/tscf_top.sv]
// Per-stage configuration bank with AXI4-Lite access and decoded outputs
//
// What this block does
// - Each of the twelve stages has its own routing, offset and sensitivity words, used only for that stage.
// - Inputs seven to thirteen each take a two-bit code: open, negative, positive or bias.
// - Upper routing bit 14 low turns the negative offset injector on, high turns it off.
// - Upper routing bit 15 low turns the positive offset injector on, high turns it off.
// - Offset bits 6:0 give the negative offset magnitude at 0.16 pF a step over about 20 pF.
// - Offset bit 7 sends the negative offset to the negative input when low, the positive when high.
// - Offset bits 14:8 give the positive offset magnitude at 0.16 pF a step.
// - Offset bit 15 sends the positive offset to the positive input when low, the negative when high.
// - Sensitivity bits 3:0 pick a negative threshold from 25% to 95.32% in sixteen steps.
// - Sensitivity bits 6:4 pick a negative peak level from 40% to 90% in ten percent steps.
// - Sensitivity bits 11:8 pick the positive threshold with the same table.
// - Sensitivity bits 14:12 pick the positive peak level with the same steps.
// - The lower routing word codes inputs zero to six the same way, bits 15:14 unused.
//
// Stage n starts at word index 0x080 plus 8n; its first four words are
// lower routing, upper routing, offset control and sensitivity.
// Other words of a stage and any address outside the bank get a slave
// error and leave storage alone.
// A write is stored two edges after both halves are taken; a read
// answers one edge after its address is taken.
// The decode follows the stage select one edge later.
// Limitation: words come up as zero; software must not rely on it.
// Byte strobes 3:2 are ignored; each word holds sixteen bits.
// Readies are registered and reopen on the same edge that a slot empties with no answer pending.
//
// The placing of the registers and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module tscf_top
  import tscf_pkg::*;
#(
  parameter int STAGES = NUM_STAGES
) (
  input wire logic aclk,                 // System clock, 50 MHz
  input wire logic aresetn,              // Synchronous reset, active low
  input wire logic [11:0] s_axi_awaddr,  // Write address
  input wire logic [2:0] s_axi_awprot,   // Write protection, ignored
  input wire logic s_axi_awvalid,        // Write address valid
  output logic s_axi_awready,            // Write address ready
  input wire logic [31:0] s_axi_wdata,   // Write data
  input wire logic [3:0] s_axi_wstrb,    // Write byte strobes
  input wire logic s_axi_wvalid,         // Write data valid
  output logic s_axi_wready,             // Write data ready
  output logic [1:0] s_axi_bresp,        // Write response
  output logic s_axi_bvalid,             // Write response valid
  input wire logic s_axi_bready,         // Write response ready
  input wire logic [11:0] s_axi_araddr,  // Read address
  input wire logic [2:0] s_axi_arprot,   // Read protection, ignored
  input wire logic s_axi_arvalid,        // Read address valid
  output logic s_axi_arready,            // Read address ready
  output logic [31:0] s_axi_rdata,       // Read data
  output logic [1:0] s_axi_rresp,        // Read response
  output logic s_axi_rvalid,             // Read data valid
  input wire logic s_axi_rready,         // Read data ready
  input wire logic [3:0] stage_sel,      // Stage now being converted
  output tscf_stage_t stage_cfg,         // Registered decode of that stage
  output logic stage_sel_bad             // Selected stage does not exist
);

  // Address decode result
  // A miss covers unused stage words as well as foreign addresses
  typedef struct packed {
    logic hit;
    logic [3:0] stage;
    logic [1:0] sub;
  } tscf_hit_t;

  // Map a byte address to stage and word; offset and clamp words miss
  function automatic tscf_hit_t decode_addr(input logic [11:0] addr);
    logic [9:0] idx;
    logic [9:0] rel;
    tscf_hit_t h;
    idx = addr[11:2];
    rel = idx - STAGE_BASE_IDX;
    h.stage = rel[6:3];
    h.sub = rel[1:0];
    // Inside the bank, one of a stage's first four words, a real stage
    h.hit = (idx >= STAGE_BASE_IDX) && (idx <= STAGE_LAST_IDX) &&
            (rel[2] == 1'b0) && (32'(h.stage) < STAGES);
    decode_addr = h;
  endfunction

  // Stored words: four per stage
  // An array, so a stage count change resizes the whole bank
  logic [15:0] cfg_mem_reg [STAGES][4];
  logic [15:0] cfg_mem_next [STAGES][4];

  // Write channel holding registers
  logic aw_held_reg, aw_held_next;
  logic [11:0] aw_addr_reg, aw_addr_next;
  logic w_held_reg, w_held_next;
  logic [31:0] w_data_reg, w_data_next;
  logic [3:0] w_strb_reg, w_strb_next;
  logic bvalid_reg, bvalid_next;
  logic [1:0] bresp_reg, bresp_next;
  logic awready_reg, awready_next;
  logic wready_reg, wready_next;

  // Read channel registers
  logic rvalid_reg, rvalid_next;
  logic [31:0] rdata_reg, rdata_next;
  logic [1:0] rresp_reg, rresp_next;
  logic arready_reg, arready_next;

  // Decoded output registers
  tscf_stage_t cfg_out_reg, cfg_out_next;
  logic sel_bad_reg, sel_bad_next;

  // Write strobe and the two address decodes
  logic do_write;
  tscf_hit_t wr_hit;
  tscf_hit_t rd_hit;
  // One decoded copy per stage; only the selected one leaves
  tscf_stage_t dec_all [STAGES];

  // Ready only while the slot is empty and no response is pending.
  // Kept in flip-flops so no output passes a gate after its register;
  // the master sees a clean level.
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_arready = arready_reg;

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign stage_cfg = cfg_out_reg;
  assign stage_sel_bad = sel_bad_reg;

  // Write fires once address and data are both held,
  // and waits while an answer is pending so answers never overlap
  assign do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_hit = decode_addr(aw_addr_reg);
  assign rd_hit = decode_addr(s_axi_araddr);

  // Write address and data capture, taken in either order
  // A held half waits for its partner, so a master may send them apart
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_addr_next = aw_addr_reg;
    w_held_next = w_held_reg;
    w_data_next = w_data_reg;
    w_strb_next = w_strb_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      w_data_next = s_axi_wdata;
      w_strb_next = s_axi_wstrb;
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit.hit ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    // Slots reopen only when empty and no answer is waiting
    awready_next = ~aw_held_next & ~bvalid_next;
    wready_next = ~w_held_next & ~bvalid_next;
  end

  // Write channel registers; both readies come up high in reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h00000000;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
    end else begin
      aw_held_reg <= aw_held_next;
      aw_addr_reg <= aw_addr_next;
      w_held_reg <= w_held_next;
      w_data_reg <= w_data_next;
      w_strb_reg <= w_strb_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      awready_reg <= awready_next;
      wready_reg <= wready_next;
    end
  end

  // Storage update; each word only changes under its own address.
  // Unused bits are stored as written, so readback shows host mistakes.
  always_comb begin
    cfg_mem_next = cfg_mem_reg;
    if (do_write && wr_hit.hit) begin
      // Only the two low strobes cover stored bits
      for (int b = 0; b < 2; b++) begin
        if (w_strb_reg[b]) begin
          cfg_mem_next[wr_hit.stage][wr_hit.sub][8*b +: 8] =
            w_data_reg[8*b +: 8];
        end
      end
    end
  end

  // Fields have no meaningful reset; zero keeps every switch open
  // Zero also leaves both injectors on at code zero, adding nothing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int s = 0; s < STAGES; s++) begin
        for (int r = 0; r < 4; r++) begin
          cfg_mem_reg[s][r] <= CFG_RESET;
        end
      end
    end else begin
      cfg_mem_reg <= cfg_mem_next;
    end
  end

  // Read: one cycle from address acceptance to data
  // Data come straight from storage, so a word stored on the same
  // edge is seen by the next read, not this one
  always_comb begin
    rvalid_next = rvalid_reg;
    rdata_next = rdata_reg;
    rresp_next = rresp_reg;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      if (rd_hit.hit) begin
        rdata_next = {16'h0000, cfg_mem_reg[rd_hit.stage][rd_hit.sub]};
        rresp_next = RESP_OKAY;
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = RESP_SLVERR;
      end
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    // Address slot reopens once the answer is taken
    arready_next = ~rvalid_next;
  end

  // Read answer registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
      rresp_reg <= RESP_OKAY;
      arready_reg <= 1'b1;
    end else begin
      rvalid_reg <= rvalid_next;
      rdata_reg <= rdata_next;
      rresp_reg <= rresp_next;
      arready_reg <= arready_next;
    end
  end

  // One decoder per stage; the sequencer picks among them
  // Each decoder sees only its own stage's words, so stages cannot mix
  for (genvar s = 0; s < STAGES; s++) begin : g_stage
    tscf_stage_decode u_dec (
      .lower_routing(cfg_mem_reg[s][SUB_LOWER_ROUTING]),
      .upper_routing(cfg_mem_reg[s][SUB_UPPER_ROUTING]),
      .offset_ctrl(cfg_mem_reg[s][SUB_OFFSET_CONTROL]),
      .sens_ctrl(cfg_mem_reg[s][SUB_SENSITIVITY]),
      .dec(dec_all[s])
    );
  end

  // Output select; a missing stage gives all-zero (everything open)
  // but with injectors off, the safe state for the analogue side
  // A stage number past the last one is flagged for the sequencer
  always_comb begin
    sel_bad_next = (32'(stage_sel) >= STAGES);
    cfg_out_next = '0;
    if (sel_bad_next) begin
      cfg_out_next.inject.neg_en = 1'b0;
      cfg_out_next.inject.pos_en = 1'b0;
    end else begin
      cfg_out_next = dec_all[stage_sel];
    end
  end

  // Registered so the switch matrix sees clean edges
  // Until the first edge after reset the decode reads as all zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_out_reg <= '0;
      sel_bad_reg <= 1'b0;
    end else begin
      cfg_out_reg <= cfg_out_next;
      sel_bad_reg <= sel_bad_next;
    end
  end

endmodule

// [verification/tscf_properties.sv]
// Port-level checker for the stage configuration bank
`timescale 1ns/1ps
module tscf_checker
  import tscf_pkg::*;
#(
  parameter int STAGES = NUM_STAGES
) (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Reset, low
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic [1:0] s_axi_bresp, // B code
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [3:0] stage_sel, // Stage asked
  input wire tscf_stage_t stage_cfg, // Decoded stage
  input wire logic stage_sel_bad // No such stage
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Defined peak codes give a ten-percent level, others give nothing
  property p_peak(logic ok, logic [6:0] pct);
    $past(aresetn) && !stage_sel_bad |->
      (ok ? (pct >= 7'h28 && pct <= 7'h5a && pct % 10 == 0) : pct == 0);
  endproperty

  AST_SEL_BAD: assert property (
    $past(aresetn) |-> stage_sel_bad == ($past(stage_sel) >= STAGES))
    else $error("stage_sel_bad does not follow stage_sel");
  AST_BAD_ZERO: assert property (
    stage_sel_bad |-> stage_cfg == '0)
    else $error("missing stage drives settings");
  AST_NEG_TRIP: assert property (
    $past(aresetn) && !stage_sel_bad |->
      stage_cfg.sense.neg_trip_x100 inside {[14'h09c4:14'h253c]})
    else $error("negative trip outside range");
  AST_POS_TRIP: assert property (
    $past(aresetn) && !stage_sel_bad |->
      stage_cfg.sense.pos_trip_x100 inside {[14'h09c4:14'h253c]})
    else $error("positive trip outside range");
  AST_NEG_PEAK: assert property (
    p_peak(stage_cfg.sense.neg_peak_ok, stage_cfg.sense.neg_peak_pct))
    else $error("negative peak level wrong");
  AST_POS_PEAK: assert property (
    p_peak(stage_cfg.sense.pos_peak_ok, stage_cfg.sense.pos_peak_pct))
    else $error("positive peak level wrong");
  AST_ROUTE_EXCL: assert property (
    ((stage_cfg.route.to_neg & stage_cfg.route.to_pos) |
     (stage_cfg.route.to_neg & stage_cfg.route.to_bias) |
     (stage_cfg.route.to_pos & stage_cfg.route.to_bias)) == 14'h0000)
    else $error("input routed two ways");
  AST_WR_RESP: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_RD_RESP: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_RD_DONE: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read answer not released");
  AST_RD_UPPER: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("read data above bit 15");

  // Main scenarios reached
  cover property (stage_sel_bad);
  cover property (!stage_sel_bad && !stage_cfg.sense.neg_peak_ok);
  cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
endmodule

bind tscf_top tscf_checker #(.STAGES(STAGES)) u_tscf_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .stage_sel(stage_sel), .stage_cfg(stage_cfg),
  .stage_sel_bad(stage_sel_bad)
);

// [verification/tscf_tb_top.sv]
// Self-checking bench for the stage configuration bank
`timescale 1ns/1ps
module tscf_tb_top;
  import tscf_pkg::*;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb, stage_sel;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, stage_sel_bad;
  tscf_stage_t stage_cfg;
  int n_fail, checks;
  // Threshold table in hundredths of a percent, kept apart from the package
  localparam logic [13:0] TRIP_EXP [16] = '{14'h09c4, 14'h0b9d, 14'h0d70,
    14'h0f44, 14'h111b, 14'h12ef, 14'h14c3, 14'h1697, 14'h186b, 14'h1a42,
    14'h1c16, 14'h1dea, 14'h1fc0, 14'h2194, 14'h2368, 14'h253c};
  localparam logic [15:0] OFS [4] = '{16'h0000, 16'h807f, 16'h7f80, 16'h2a55};
  localparam logic [9:0] BAD_IX [4] = '{10'h084, 10'h0df, 10'h0e0, 10'h07f};

  tscf_top #(.STAGES(NUM_STAGES)) dut (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awprot(s_axi_awprot), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .stage_sel(stage_sel), .stage_cfg(stage_cfg),
    .stage_sel_bad(stage_sel_bad)
  );

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic finish_test();
    if (n_fail == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  function automatic logic [9:0] ix(input int s, input int sub);
    return STAGE_BASE_IDX + 10'(s * 8 + sub);
  endfunction

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [9:0] idx, input logic [15:0] d,
      input logic [3:0] st, input logic [1:0] er);
    logic aw_p, w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    chk("bresp", 32'(s_axi_bresp), 32'(er));
  endtask

  task automatic rd(input logic [9:0] idx, input logic [15:0] ed,
      input logic [1:0] er);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    chk("rdata", s_axi_rdata, {16'h0000, ed});
    chk("rresp", 32'(s_axi_rresp), 32'(er));
  endtask

  // New stage lands in the decode register one edge later
  task automatic sel(input logic [3:0] s);
    stage_sel <= s;
    repeat (2) @(posedge aclk);
  endtask

  // Hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    finish_test();
  end

  // Main sequence; response channels stay ready throughout
  initial begin
    logic [15:0] lw, uw, d;
    int u, p;
    n_fail = 0;
    checks = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awprot, s_axi_arprot, stage_sel} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    sel(4'h0);
    chk("neg_en", 32'(stage_cfg.inject.neg_en), 32'h1);
    chk("trip", 32'(stage_cfg.sense.neg_trip_x100), 32'h9c4);
    chk("peak", 32'(stage_cfg.sense.pos_peak_pct), 32'h28);
    for (int k = 0; k < 4; k++) rd(ix(0, k), 16'h0000, RESP_OKAY);
    // Lower and upper halves carry different codes to catch a swap
    for (int c = 0; c < 4; c++) begin
      u = (c + 1) % 4;
      lw = {2'(c), {7{2'(c)}}};
      uw = {2'(u), {7{2'(u)}}};
      wr(ix(3, 0), lw, 4'hf, RESP_OKAY);
      wr(ix(3, 1), uw, 4'hf, RESP_OKAY);
      rd(ix(3, 0), lw, RESP_OKAY);
      sel(4'h3);
      chk("to_neg", 32'(stage_cfg.route.to_neg),
        32'({{7{u == 1}}, {7{c == 1}}}));
      chk("to_pos", 32'(stage_cfg.route.to_pos),
        32'({{7{u == 2}}, {7{c == 2}}}));
      chk("to_bias", 32'(stage_cfg.route.to_bias),
        32'({{7{u == 3}}, {7{c == 3}}}));
      chk("neg_en", 32'(stage_cfg.inject.neg_en), 32'(!uw[14]));
      chk("pos_en", 32'(stage_cfg.inject.pos_en), 32'(!uw[15]));
    end
    for (int k = 0; k < 4; k++) begin
      d = OFS[k];
      wr(ix(7, 2), d, 4'hf, RESP_OKAY);
      sel(4'h7);
      chk("ncode", 32'(stage_cfg.inject.neg_code), 32'(d[6:0]));
      chk("nsteer", 32'(stage_cfg.inject.neg_to_pos), 32'(d[7]));
      chk("pcode", 32'(stage_cfg.inject.pos_code), 32'(d[14:8]));
      chk("psteer", 32'(stage_cfg.inject.pos_to_neg), 32'(d[15]));
    end
    // Every trip code once, peak codes including the undefined pair
    for (int t = 0; t < 16; t++) begin
      p = t % 8;
      d = {1'b0, 3'(p), 4'(15 - t), 1'b0, 3'(p), 4'(t)};
      wr(ix(11, 3), d, 4'hf, RESP_OKAY);
      sel(4'hb);
      chk("ntrip", 32'(stage_cfg.sense.neg_trip_x100),
        32'(TRIP_EXP[t]));
      chk("ptrip", 32'(stage_cfg.sense.pos_trip_x100),
        32'(TRIP_EXP[15 - t]));
      chk("npeak", 32'(stage_cfg.sense.neg_peak_pct),
        (p <= 5) ? 32'(40 + 10 * p) : 32'h0);
      chk("ppeak", 32'(stage_cfg.sense.pos_peak_pct),
        (p <= 5) ? 32'(40 + 10 * p) : 32'h0);
      chk("pok", 32'(stage_cfg.sense.pos_peak_ok), 32'(p <= 5));
      chk("nok", 32'(stage_cfg.sense.neg_peak_ok), 32'(p <= 5));
      rd(ix(11, 3), d, RESP_OKAY);
    end
    rd(ix(10, 3), 16'h0000, RESP_OKAY);
    rd(ix(4, 2), 16'h0000, RESP_OKAY);
    sel(4'ha);
    chk("iso", 32'(stage_cfg.sense.pos_trip_x100), 32'h9c4);
    wr(ix(11, 2), 16'hbeef, 4'h2, RESP_OKAY);
    rd(ix(11, 2), 16'hbe00, RESP_OKAY);
    // Offset, clamp and results words are outside this bank
    for (int k = 0; k < 4; k++) begin
      wr(BAD_IX[k], 16'h1111, 4'hf, RESP_SLVERR);
      rd(BAD_IX[k], 16'h0000, RESP_SLVERR);
    end
    rd(ix(0, 3), 16'h0000, RESP_OKAY);
    sel(4'hc);
    chk("bad12", 32'(stage_sel_bad), 32'h1);
    sel(4'hf);
    chk("zero", 32'(stage_cfg !== '0), 32'h0);
    finish_test();
  end
endmodule
